// File: pkg/bt_exec_pkg.sv
package bt_exec_pkg;

	// opcode bytes decoded by the execution block
	localparam logic [7:0] OPC_JUMP_IF_BIT_SET = 8'h20;
	localparam logic [7:0] OPC_INDIRECT_JUMP = 8'h73;
	// no fixed code exists for the test-and-clear form; the top module takes it as a parameter
	localparam logic [7:0] OPC_BIT_SET_CLEAR_DEFAULT = 8'h10;

	// instruction lengths in bytes
	localparam logic [15:0] LEN_BIT_BRANCH = 16'h0003;
	localparam logic [15:0] LEN_INDIRECT = 16'h0001;

	// machine cycles per instruction
	localparam int unsigned CYCLES_BIT_BRANCH = 2;
	localparam int unsigned CYCLES_INDIRECT = 2;

	// values after reset
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// value written into a bit by the clearing form
	localparam logic BIT_CLEARED = 1'b0;

	// one decoded instruction as handed over by fetch
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] operand1; // bit address for bit branches
		logic [7:0] operand2; // signed displacement for bit branches
		logic [15:0] pc; // address of the opcode byte
	} instr_t;

	// bit-space access request
	typedef struct packed {
		logic [7:0] addr;
		logic from_latch; // read port bits from the output latch, not the pins
	} bit_req_t;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_BIT_SET,
		OP_BIT_SET_CLEAR,
		OP_INDIRECT
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC
	} state_t;

endpackage

// File: verilog/bit_test_and_indirect_branch_exec.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - jump_if_bit_set branches to the computed target when the addressed bit is one, else falls through.
// - jump_if_bit_set is opcode 0x20 with bit address and displacement bytes, three bytes, two cycles.
// - both bit branches add the signed third byte to the program counter already advanced by three.
// - jump_if_bit_set never writes the tested bit and never touches a flag.
// - jump_if_bit_set_then_clear, on a one bit, branches and writes the bit to zero with no flag change.
// - jump_if_bit_set_then_clear, on a zero bit, issues no write and falls through.
// - jump_if_bit_set_then_clear reads a port bit from its output latch instead of the pin.
// - indirect_jump_acc_plus_pointer loads the program counter with zero-extended acc plus the pointer.
// - the indirect addition is a full 16-bit add that wraps and carries into the high byte.
// - the indirect jump leaves acc, the pointer and every flag untouched.
module bit_test_and_indirect_branch_exec #(
	parameter logic [7:0] CLEAR_OPCODE = bt_exec_pkg::OPC_BIT_SET_CLEAR_DEFAULT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire bt_exec_pkg::instr_t instr,
	input wire logic [7:0] acc,
	input wire logic [15:0] sixteen_bit_data_pointer,
	input wire logic bit_rdata,
	output logic busy_ff,
	output logic bit_rd_ff,
	output bt_exec_pkg::bit_req_t bit_rd_req_ff,
	output logic bit_wr_ff,
	output logic [7:0] bit_wr_addr_ff,
	output logic bit_wr_data_ff,
	output logic done_ff,
	output logic pc_load_ff,
	output logic [15:0] pc_next_ff,
	output logic taken_ff,
	output logic unknown_op_ff
);

	bt_exec_pkg::state_t state_ff;
	bt_exec_pkg::state_t nxt_state;
	bt_exec_pkg::op_t op_ff;
	bt_exec_pkg::op_t nxt_op;
	logic [15:0] fall_pc_ff;
	logic [15:0] branch_pc_ff;
	logic [15:0] indirect_pc_ff;
	logic [7:0] bit_addr_ff;
	logic [15:0] nxt_fall_pc;
	logic [15:0] nxt_branch_pc;
	logic [15:0] rel_ext;
	logic [15:0] acc_ext;
	logic accept;
	logic finish;
	logic bit_one;

	// a new instruction is only taken while idle; fetch must hold off while busy
	assign accept = start && (state_ff == bt_exec_pkg::ST_IDLE);
	assign finish = (state_ff == bt_exec_pkg::ST_EXEC);
	assign bit_one = bit_rdata;

	// decode the opcode byte into one of the three handled forms
	always_comb begin
		nxt_op = bt_exec_pkg::OP_NONE;
		if (instr.opcode == bt_exec_pkg::OPC_JUMP_IF_BIT_SET) begin
			nxt_op = bt_exec_pkg::OP_BIT_SET;
		end else if (instr.opcode == CLEAR_OPCODE) begin
			nxt_op = bt_exec_pkg::OP_BIT_SET_CLEAR;
		end else if (instr.opcode == bt_exec_pkg::OPC_INDIRECT_JUMP) begin
			nxt_op = bt_exec_pkg::OP_INDIRECT;
		end
	end

	// sign extension of the displacement byte
	assign rel_ext = {{8{instr.operand2[7]}}, instr.operand2};

	// fall-through address: past the whole instruction
	always_comb begin
		nxt_fall_pc = instr.pc + bt_exec_pkg::LEN_BIT_BRANCH;
		// the indirect form never falls through, this only keeps the value tidy
		if (nxt_op == bt_exec_pkg::OP_INDIRECT) begin
			nxt_fall_pc = instr.pc + bt_exec_pkg::LEN_INDIRECT;
		end
	end

	// targets are formed at acceptance so the second cycle only selects between them
	// the sum wraps at 16 bits, so a branch near the top of memory lands at the bottom
	assign nxt_branch_pc = nxt_fall_pc + rel_ext;

	// zero extension of acc; the 16-bit sum wraps naturally and carries across bytes
	assign acc_ext = {8'h00, acc};

	// two-state sequencer: accept, then finish one machine cycle later
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			bt_exec_pkg::ST_IDLE: begin
				if (start && (nxt_op != bt_exec_pkg::OP_NONE)) begin
					nxt_state = bt_exec_pkg::ST_EXEC;
				end
			end
			bt_exec_pkg::ST_EXEC: begin
				nxt_state = bt_exec_pkg::ST_IDLE;
			end
			default: begin
				nxt_state = bt_exec_pkg::ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= bt_exec_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// busy mirrors the execute state so fetch can see the block is occupied
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_ff <= 1'b0;
		end else begin
			busy_ff <= (nxt_state == bt_exec_pkg::ST_EXEC);
		end
	end

	// operation kind held through the execute cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			op_ff <= bt_exec_pkg::OP_NONE;
		end else if (accept) begin
			op_ff <= nxt_op;
		end
	end

	// fall-through address captured at acceptance
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fall_pc_ff <= bt_exec_pkg::PC_RESET;
		end else if (accept) begin
			fall_pc_ff <= nxt_fall_pc;
		end
	end

	// relative target captured at acceptance
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			branch_pc_ff <= bt_exec_pkg::PC_RESET;
		end else if (accept) begin
			branch_pc_ff <= nxt_branch_pc;
		end
	end

	// indirect target captured at acceptance
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			indirect_pc_ff <= bt_exec_pkg::PC_RESET;
		end else if (accept) begin
			// acc and pointer are only sampled, never written back
			indirect_pc_ff <= sixteen_bit_data_pointer + acc_ext;
		end
	end

	// bit address kept for the clearing write a cycle later
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_addr_ff <= bt_exec_pkg::BYTE_RESET;
		end else if (accept) begin
			bit_addr_ff <= instr.operand1;
		end
	end

	// bit read strobe stands for the whole execute cycle; data is sampled at its end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_rd_ff <= 1'b0;
		end else begin
			bit_rd_ff <= accept && ((nxt_op == bt_exec_pkg::OP_BIT_SET) ||
				(nxt_op == bt_exec_pkg::OP_BIT_SET_CLEAR));
		end
	end

	// address and source of the read; zero outside the strobe so no stale address leaks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_rd_req_ff <= '0;
		end else if (accept && ((nxt_op == bt_exec_pkg::OP_BIT_SET) ||
				(nxt_op == bt_exec_pkg::OP_BIT_SET_CLEAR))) begin
			bit_rd_req_ff.addr <= instr.operand1;
			// read-modify-write form must see what the core drove, not the pin level
			bit_rd_req_ff.from_latch <= (nxt_op == bt_exec_pkg::OP_BIT_SET_CLEAR);
		end else begin
			bit_rd_req_ff <= '0;
		end
	end

	// clearing write only for the clear form and only when the bit was one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_wr_ff <= 1'b0;
		end else begin
			// the plain test form and a zero bit both leave the bit alone
			bit_wr_ff <= finish && (op_ff == bt_exec_pkg::OP_BIT_SET_CLEAR) &&
				bit_one;
		end
	end

	// write address valid with the strobe, zero otherwise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_wr_addr_ff <= bt_exec_pkg::BYTE_RESET;
		end else if (finish && (op_ff == bt_exec_pkg::OP_BIT_SET_CLEAR) && bit_one) begin
			bit_wr_addr_ff <= bit_addr_ff;
		end else begin
			bit_wr_addr_ff <= bt_exec_pkg::BYTE_RESET;
		end
	end

	// the clear form only ever writes zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_wr_data_ff <= bt_exec_pkg::BIT_CLEARED;
		end else begin
			bit_wr_data_ff <= bt_exec_pkg::BIT_CLEARED;
		end
	end

	// program counter load pulses at the end of the second cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_load_ff <= 1'b0;
		end else begin
			pc_load_ff <= finish;
		end
	end

	// new program counter; holds its last value so a late reader still sees it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_next_ff <= bt_exec_pkg::PC_RESET;
		end else if (finish) begin
			case (op_ff)
				bt_exec_pkg::OP_BIT_SET,
				bt_exec_pkg::OP_BIT_SET_CLEAR: begin
					pc_next_ff <= bit_one ? branch_pc_ff : fall_pc_ff;
				end
				bt_exec_pkg::OP_INDIRECT: begin
					pc_next_ff <= indirect_pc_ff;
				end
				default: begin
					pc_next_ff <= fall_pc_ff;
				end
			endcase
		end
	end

	// branch outcome, valid with done and held until the next completion
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			taken_ff <= 1'b0;
		end else if (finish) begin
			case (op_ff)
				bt_exec_pkg::OP_BIT_SET,
				bt_exec_pkg::OP_BIT_SET_CLEAR: begin
					taken_ff <= bit_one;
				end
				bt_exec_pkg::OP_INDIRECT: begin
					// the indirect form always transfers control
					taken_ff <= 1'b1;
				end
				default: begin
					taken_ff <= 1'b0;
				end
			endcase
		end
	end

	// completion pulse, one cycle, together with the load
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= finish;
		end
	end

	// an unhandled opcode is refused and only reported, so fetch can trap it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			unknown_op_ff <= 1'b0;
		end else begin
			unknown_op_ff <= accept && (nxt_op == bt_exec_pkg::OP_NONE);
		end
	end

endmodule // bit_test_and_indirect_branch_exec

`default_nettype wire

// File: dv/bt_exec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// timing and result checks on the execution block ports
module bt_exec_chk #(
	parameter logic [7:0] CLEAR_OPCODE = bt_exec_pkg::OPC_BIT_SET_CLEAR_DEFAULT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire bt_exec_pkg::instr_t instr,
	input wire logic [7:0] acc,
	input wire logic [15:0] sixteen_bit_data_pointer,
	input wire logic bit_rdata,
	input wire logic busy_ff,
	input wire logic bit_rd_ff,
	input wire bt_exec_pkg::bit_req_t bit_rd_req_ff,
	input wire logic bit_wr_ff,
	input wire logic [7:0] bit_wr_addr_ff,
	input wire logic bit_wr_data_ff,
	input wire logic done_ff,
	input wire logic pc_load_ff,
	input wire logic [15:0] pc_next_ff,
	input wire logic taken_ff,
	input wire logic unknown_op_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic go_bit, go_clr, go_ind;
	logic [15:0] rel_ext;
	// accepted requests per opcode; busy requests are ignored
	assign go_bit = start && !busy_ff && instr.opcode == 8'h20;
	assign go_clr = start && !busy_ff && instr.opcode == CLEAR_OPCODE;
	assign go_ind = start && !busy_ff && instr.opcode == 8'h73;
	assign rel_ext = {{8{instr.operand2[7]}}, instr.operand2};
	two_cycle_a: assert property ((go_bit || go_clr || go_ind) |=> busy_ff ##1
		(done_ff && pc_load_ff && !busy_ff)) else $error("done not two cycles on");
	bit_addr_a: assert property (go_bit |=>
		bit_rd_ff && bit_rd_req_ff == {$past(instr.operand1), 1'b0}) else $error("bad bit read");
	latch_read_a: assert property (go_clr |=> bit_rd_ff && bit_rd_req_ff.from_latch)
		else $error("clear form reads pins");
	keep_bit_a: assert property (go_bit |=> ##1 !bit_wr_ff) else $error("bit written");
	clear_src_a: assert property (bit_wr_ff |-> $past(bit_rd_ff && bit_rdata) &&
		bit_wr_addr_ff == $past(bit_rd_req_ff.addr) && !bit_wr_data_ff) else $error("bad clear");
	clear_due_a: assert property (bit_rd_ff && bit_rd_req_ff.from_latch && bit_rdata
		|=> bit_wr_ff) else $error("clear missing");
	taken_bit_a: assert property (bit_rd_ff |=> taken_ff == $past(bit_rdata))
		else $error("taken wrong");
	rel_target_a: assert property ((go_bit || go_clr) |=> ##1 pc_next_ff ==
		$past(instr.pc, 2) + 16'h0003 + (taken_ff ? $past(rel_ext, 2) : 16'h0000))
		else $error("branch target wrong");
	ind_sum_a: assert property (go_ind |=> !bit_rd_ff ##1 (taken_ff &&
		pc_next_ff == $past(sixteen_bit_data_pointer, 2) + {8'h00, $past(acc, 2)}))
		else $error("indirect target wrong");
	cover property (go_clr ##2 bit_wr_ff);
	cover property (go_bit ##2 taken_ff);
	cover property (go_ind ##2 done_ff);
endmodule // bt_exec_chk
bind bit_test_and_indirect_branch_exec bt_exec_chk #(.CLEAR_OPCODE(CLEAR_OPCODE)) i_chk (.*);
`default_nettype wire

// File: dv/bit_space_model.sv
`timescale 1ns/1ps
`default_nettype none
// bit space behind the core: latches, with pins reading the inverse
module bit_space_model (
	input wire logic clk,
	input wire logic bit_rd_ff,
	input wire bt_exec_pkg::bit_req_t bit_rd_req_ff,
	input wire logic bit_wr_ff,
	input wire logic [7:0] bit_wr_addr_ff,
	input wire logic bit_wr_data_ff,
	output logic bit_rdata
);
	logic latch [256];
	logic idle_ff = 1'b0;
	// plain always so the bench may preset latch bits too
	always @(posedge clk) begin
		idle_ff <= !idle_ff;
		if (bit_wr_ff) latch[bit_wr_addr_ff] <= bit_wr_data_ff;
	end
	// toggles when not read, so a stale sample cannot pass
	assign bit_rdata = !bit_rd_ff ? idle_ff : bit_rd_req_ff.from_latch ?
		latch[bit_rd_req_ff.addr] : !latch[bit_rd_req_ff.addr];
endmodule // bit_space_model
`default_nettype wire

// File: dv/bit_test_and_indirect_branch_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
module bit_test_and_indirect_branch_exec_test;
	logic clk = 1'b0, rst = 1'b1, start = 1'b0;
	bt_exec_pkg::instr_t instr = '0;
	logic [7:0] acc = 8'h00;
	logic [15:0] sixteen_bit_data_pointer = 16'h0000;
	logic busy_ff, bit_rd_ff, bit_wr_ff, bit_wr_data_ff, done_ff, pc_load_ff;
	logic taken_ff, unknown_op_ff, bit_rdata;
	bt_exec_pkg::bit_req_t bit_rd_req_ff;
	logic [7:0] bit_wr_addr_ff;
	logic [15:0] pc_next_ff;
	int fails = 0, cmp_count = 0;
	logic [31:0] lfsr = 32'h00016e07;
	logic [7:0] ops [4] = '{8'h20, 8'h10, 8'h73, 8'h5a};
	always #2.5 clk = !clk;
	bit_test_and_indirect_branch_exec i_dut (.*);
	bit_space_model i_mem (.*);
	function automatic logic [31:0] step(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] target(logic [15:0] pc, logic [7:0] rel, logic b);
		return pc + 16'h0003 + (b ? {{8{rel[7]}}, rel} : 16'h0000);
	endfunction
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, s);
			fails++;
		end
	endtask
	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one instruction; b is the latch value, the pin reads its inverse
	task automatic run(logic [7:0] op, logic [7:0] a, logic [7:0] r, logic [15:0] pc,
		logic [7:0] ac, logic [15:0] p, logic b);
		logic hit, bv;
		hit = op == 8'h20 || op == 8'h10 || op == 8'h73;
		bv = op == 8'h20 ? !b : b;
		@(posedge clk);
		#1;
		i_mem.latch[a] = b;
		instr = {op, a, r, pc};
		acc = ac;
		sixteen_bit_data_pointer = p;
		start = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		chk("busy", {15'h0000, hit}, {15'h0000, busy_ff});
		chk("unknown", {15'h0000, !hit}, {15'h0000, unknown_op_ff});
		chk("bit read", {15'h0000, hit && op != 8'h73}, {15'h0000, bit_rd_ff});
		@(posedge clk);
		#1;
		chk("done", {15'h0000, hit}, {15'h0000, done_ff});
		if (op == 8'h73) chk("pc", p + {8'h00, ac}, pc_next_ff);
		else if (hit) chk("pc", target(pc, r, bv), pc_next_ff);
		if (hit) chk("taken", {15'h0000, op == 8'h73 || bv}, {15'h0000, taken_ff});
		chk("write", {15'h0000, op == 8'h10 && b}, {15'h0000, bit_wr_ff});
	endtask
	// corner cases first, then random traffic
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		run(8'h73, 8'h00, 8'h00, 16'h0000, 8'hff, 16'hff01, 1'b0);
		run(8'h73, 8'h00, 8'h00, 16'h0000, 8'h01, 16'h00ff, 1'b0);
		run(8'h20, 8'h90, 8'h80, 16'h0010, 8'h00, 16'h0000, 1'b0);
		run(8'h10, 8'ha0, 8'h7f, 16'hfffe, 8'h00, 16'h0000, 1'b1);
		run(8'h10, 8'ha0, 8'h05, 16'h1234, 8'h00, 16'h0000, 1'b0);
		for (int i = 0; i < 300; i++) begin
			repeat (16) lfsr = step(lfsr);
			run(ops[lfsr[1:0]], lfsr[9:2], lfsr[17:10], lfsr[31:16], lfsr[25:18],
				{lfsr[7:0], lfsr[31:24]}, lfsr[5]);
		end
		print_verdict();
	end
	// about 930 cycles are needed
	initial begin
		#(5 * 3000);
		fails++;
		print_verdict();
	end
endmodule // bit_test_and_indirect_branch_exec_test
`default_nettype wire
